// ===== oope_defines.svh
// Functional notes
// - OR sets bit if either operand bit set
// - OR updates carry, overflow, parity, zero flags
// - OR accepts six operand forms
// - Port output sends low byte or full accumulator
// - Immediate port form reaches ports 0 to 255
// - Index register port form reaches all 65536 ports
// - Output, string output, pop leave flags untouched
// - String output reads source index, writes indexed port
// - String read uses data segment unless overridden
// - Source index steps up or down by direction
// - Source index step is 1 byte, 2 word
// - Repeated string output gives block output
// - Pop loads word: low at pointer, high next
// - Pop then adds two to stack pointer
// - Pop to register, segment or memory; never code segment
`ifndef OOPE_DEFINES_SVH
`define OOPE_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OOPE_CMD_OFS    8'h00
`define OOPE_STATUS_OFS 8'h04
`define OOPE_ACCUM_OFS  8'h08
`define OOPE_PORT_OFS   8'h0c
`define OOPE_SRC_OFS    8'h10
`define OOPE_SP_OFS     8'h14
`define OOPE_FLAGS_OFS  8'h18
`define OOPE_OPA_OFS    8'h1c
`define OOPE_OPB_OFS    8'h20
`define OOPE_MOFS_OFS   8'h24
`define OOPE_COUNT_OFS  8'h28
`define OOPE_IMM8_OFS   8'h2c
`define OOPE_SEG0_OFS   8'h30
`define OOPE_SEG_LAST   8'h3c

// ****************************************
// Command fields
// ****************************************
`define OOPE_CMD_OP     1:0
`define OOPE_CMD_FORM   4:2
`define OOPE_CMD_WORD   5
`define OOPE_CMD_REP    6
`define OOPE_CMD_IDX    7
`define OOPE_CMD_OVR    8
`define OOPE_CMD_PDST   10:9
`define OOPE_CMD_SEG    12:11
`define OOPE_CMD_W      13

// ****************************************
// Bit positions and constants
// ****************************************
`define OOPE_ST_BUSY    0
`define OOPE_ST_ILLEGAL 1
`define OOPE_ST_EMPTY   2
`define OOPE_ST_FULL    3
`define OOPE_FLG_CF     0
`define OOPE_FLG_PF     2
`define OOPE_FLG_ZF     6
`define OOPE_FLG_SF     7
`define OOPE_FLG_DF     10
`define OOPE_FLG_OF     11
`define OOPE_SEG_CS     2'h1
`define OOPE_SEG_SS     2'h2
`define OOPE_SEG_DS     2'h3
`define OOPE_STEP_BYTE  16'h0001
`define OOPE_STEP_WORD  16'h0002
`define OOPE_POP_STEP   16'h0002
`define OOPE_REG_RST    16'h0000
`define OOPE_FIFO_DEPTH 8

`endif

// ===== oope_pkg.sv
package oope_pkg;
  typedef enum logic [1:0] {OOPE_OR, OOPE_OUT, OOPE_STRING_OUTPUT_INSTR, OOPE_POP} oope_op_t;
  typedef enum logic [2:0] {
    FORM_RR, FORM_RM, FORM_MR, FORM_AI, FORM_RI, FORM_MI, FORM_BAD6, FORM_BAD7
  } oope_form_t;
  typedef enum logic [1:0] {PDST_REG, PDST_SEG, PDST_MEM, PDST_BAD} oope_pdst_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_MRD, ST_EXEC, ST_MWR, ST_IOQ, ST_SRD, ST_SPUSH, ST_PRD, ST_PWR
  } oope_state_t;
endpackage

// ===== oope_exec.sv
`timescale 1ns/100ps
`include "oope_defines.svh"

// ****************************************
// Port write FIFO
// ****************************************
module oope_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // Clock, reset, enable
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Level
  output logic                  full,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready  = ce && !full;
  assign out_valid = !empty;
  assign push      = in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Storage
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ****************************************
// Execution core for or, out, string_output_instr, pop
// ****************************************
module oope_exec #(
  parameter int FIFO_DEPTH = `OOPE_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory bus
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_word,
  output logic [19:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  // I/O write bus
  output logic             io_valid,
  output logic             io_word,
  output logic [15:0]      io_addr,
  output logic [15:0]      io_data,
  input  wire logic        io_ready
);
  import oope_pkg::*;

  oope_state_t       state;
  logic [`OOPE_CMD_W-1:0] cmd_q;
  logic [15:0]       accum_word;
  logic [15:0]       port_index_reg;
  logic [15:0]       src_index;
  logic [15:0]       stack_pointer_reg;
  logic [15:0]       flags;
  logic [15:0]       opa;
  logic [15:0]       opb;
  logic [15:0]       mem_ofs;
  logic [15:0]       count;
  logic [7:0]        imm8;
  logic [15:0]       seg_reg [4];
  logic [15:0]       mem_data;
  logic              illegal;
  logic              rd_rdy;

  logic              wr_go;
  logic              wr_idle;
  logic              start;
  logic              bad_cmd;
  logic              mapped;
  logic [31:0]       rd_mux;
  oope_op_t          new_op;
  oope_form_t        new_form;
  oope_form_t        form;
  oope_pdst_t        pdst;
  logic              is_word;
  logic [15:0]       dst_val;
  logic [15:0]       src_val;
  logic [15:0]       or_res;
  logic [15:0]       res;
  logic [15:0]       dseg;
  logic [15:0]       step;
  logic              or_done;
  logic              string_output_instr_step;
  logic              pop_got;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [32:0]       fifo_in_data;
  logic [32:0]       fifo_out_data;
  logic              fifo_full;
  logic              fifo_empty;

  // ****************************************
  // APB slave
  // ****************************************
  assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= `OOPE_SEG_LAST);
  assign pready  = ce && rd_rdy && penable;
  assign pslverr = pready && !mapped;
  assign wr_go   = psel && penable && pready && pwrite && mapped;
  // Busy engine owns its registers, so writes are dropped
  assign wr_idle = wr_go && (state == ST_IDLE);

  // Read data taken in setup, so prdata is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_rdy <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (psel && penable && rd_rdy) begin
        rd_rdy <= 1'b0;
      end else if (psel) begin
        rd_rdy <= 1'b1;
        prdata <= rd_mux;
      end
    end
  end

  // Read decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == `OOPE_CMD_OFS) begin
      rd_mux = {{(32-`OOPE_CMD_W){1'b0}}, cmd_q};
    end else if (paddr == `OOPE_STATUS_OFS) begin
      rd_mux[`OOPE_ST_BUSY]    = (state != ST_IDLE);
      rd_mux[`OOPE_ST_ILLEGAL] = illegal;
      rd_mux[`OOPE_ST_EMPTY]   = fifo_empty;
      rd_mux[`OOPE_ST_FULL]    = fifo_full;
    end else if (paddr == `OOPE_ACCUM_OFS) begin
      rd_mux[15:0] = accum_word;
    end else if (paddr == `OOPE_PORT_OFS) begin
      rd_mux[15:0] = port_index_reg;
    end else if (paddr == `OOPE_SRC_OFS) begin
      rd_mux[15:0] = src_index;
    end else if (paddr == `OOPE_SP_OFS) begin
      rd_mux[15:0] = stack_pointer_reg;
    end else if (paddr == `OOPE_FLAGS_OFS) begin
      rd_mux[15:0] = flags;
    end else if (paddr == `OOPE_OPA_OFS) begin
      rd_mux[15:0] = opa;
    end else if (paddr == `OOPE_OPB_OFS) begin
      rd_mux[15:0] = opb;
    end else if (paddr == `OOPE_MOFS_OFS) begin
      rd_mux[15:0] = mem_ofs;
    end else if (paddr == `OOPE_COUNT_OFS) begin
      rd_mux[15:0] = count;
    end else if (paddr == `OOPE_IMM8_OFS) begin
      rd_mux[7:0] = imm8;
    end else if (paddr >= `OOPE_SEG0_OFS && mapped) begin
      rd_mux[15:0] = seg_reg[paddr[3:2]];
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  assign new_op   = oope_op_t'(pwdata[`OOPE_CMD_OP]);
  assign new_form = oope_form_t'(pwdata[`OOPE_CMD_FORM]);
  // Bad form, bad pop target or pop to code segment refused
  assign bad_cmd  = ((new_op == OOPE_OR) && (new_form > FORM_MI)) ||
                    ((new_op == OOPE_POP) && (pwdata[`OOPE_CMD_PDST] == PDST_BAD)) ||
                    ((new_op == OOPE_POP) && (pwdata[`OOPE_CMD_PDST] == PDST_SEG) &&
                     (pwdata[`OOPE_CMD_SEG] == `OOPE_SEG_CS));
  assign start    = wr_idle && (paddr == `OOPE_CMD_OFS) && !bad_cmd;

  assign form    = oope_form_t'(cmd_q[`OOPE_CMD_FORM]);
  assign pdst    = oope_pdst_t'(cmd_q[`OOPE_CMD_PDST]);
  assign is_word = cmd_q[`OOPE_CMD_WORD];
  assign step    = is_word ? `OOPE_STEP_WORD : `OOPE_STEP_BYTE;
  // Override replaces the data segment
  assign dseg    = cmd_q[`OOPE_CMD_OVR] ? seg_reg[cmd_q[`OOPE_CMD_SEG]]
                                        : seg_reg[`OOPE_SEG_DS];

  // ****************************************
  // OR datapath
  // ****************************************
  always_comb begin
    dst_val = opa;
    src_val = opb;
    case (form)
      FORM_RM: begin
        src_val = mem_data;
      end
      FORM_MR, FORM_MI: begin
        dst_val = mem_data;
      end
      FORM_AI: begin
        dst_val = accum_word;
      end
      default: ;
    endcase
  end

  assign or_res    = dst_val | src_val;
  assign res       = is_word ? or_res : {8'h00, or_res[7:0]};
  assign or_done   = (state == ST_EXEC);
  assign string_output_instr_step = (state == ST_SPUSH) && fifo_in_ready;
  assign pop_got   = (state == ST_PRD) && mem_ack;

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            case (new_op)
              OOPE_OR: begin
                if (new_form == FORM_RM || new_form == FORM_MR || new_form == FORM_MI) begin
                  state <= ST_MRD;
                end else begin
                  state <= ST_EXEC;
                end
              end
              OOPE_OUT: begin
                state <= ST_IOQ;
              end
              OOPE_STRING_OUTPUT_INSTR: begin
                // Zero repeat count moves nothing
                if (pwdata[`OOPE_CMD_REP] && count == 16'h0000) begin
                  state <= ST_IDLE;
                end else begin
                  state <= ST_SRD;
                end
              end
              default: begin
                state <= ST_PRD;
              end
            endcase
          end
        end
        ST_MRD: begin
          if (mem_ack) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= (form == FORM_MR || form == FORM_MI) ? ST_MWR : ST_IDLE;
        end
        ST_MWR, ST_PWR: begin
          if (mem_ack) begin
            state <= ST_IDLE;
          end
        end
        ST_IOQ: begin
          if (fifo_in_ready) begin
            state <= ST_IDLE;
          end
        end
        ST_SRD: begin
          if (mem_ack) begin
            state <= ST_SPUSH;
          end
        end
        ST_SPUSH: begin
          if (fifo_in_ready) begin
            state <= (cmd_q[`OOPE_CMD_REP] && count != 16'h0001) ? ST_SRD : ST_IDLE;
          end
        end
        ST_PRD: begin
          if (mem_ack) begin
            state <= (pdst == PDST_MEM) ? ST_PWR : ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Command latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= '0;
    end else if (ce && start) begin
      cmd_q <= pwdata[`OOPE_CMD_W-1:0];
    end
  end

  // Refused command is sticky; a new refusal beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal <= 1'b0;
    end else if (ce) begin
      if (wr_idle && paddr == `OOPE_CMD_OFS && bad_cmd) begin
        illegal <= 1'b1;
      end else if (wr_idle && paddr == `OOPE_STATUS_OFS && pwdata[`OOPE_ST_ILLEGAL]) begin
        illegal <= 1'b0;
      end
    end
  end

  // Memory read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_data <= `OOPE_REG_RST;
    end else if (ce && mem_ack && (state == ST_MRD || state == ST_SRD || state == ST_PRD)) begin
      mem_data <= mem_rdata;
    end
  end

  // ****************************************
  // Architectural registers
  // ****************************************
  // Accumulator holds OR immediate result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_word <= `OOPE_REG_RST;
    end else if (ce) begin
      if (wr_idle && paddr == `OOPE_ACCUM_OFS) begin
        accum_word <= pwdata[15:0];
      end else if (or_done && form == FORM_AI) begin
        accum_word <= is_word ? or_res : {accum_word[15:8], or_res[7:0]};
      end
    end
  end

  // Register destination of OR and pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa <= `OOPE_REG_RST;
    end else if (ce) begin
      if (wr_idle && paddr == `OOPE_OPA_OFS) begin
        opa <= pwdata[15:0];
      end else if (or_done && (form == FORM_RR || form == FORM_RM || form == FORM_RI)) begin
        opa <= is_word ? or_res : {opa[15:8], or_res[7:0]};
      end else if (pop_got && pdst == PDST_REG) begin
        opa <= mem_rdata;
      end
    end
  end

  // Flags change only on OR
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= `OOPE_REG_RST;
    end else if (ce) begin
      if (wr_idle && paddr == `OOPE_FLAGS_OFS) begin
        flags <= pwdata[15:0];
      end else if (or_done) begin
        flags[`OOPE_FLG_CF] <= 1'b0;
        flags[`OOPE_FLG_OF] <= 1'b0;
        flags[`OOPE_FLG_PF] <= ~^res[7:0];
        flags[`OOPE_FLG_ZF] <= (res == 16'h0000);
        flags[`OOPE_FLG_SF] <= is_word ? res[15] : res[7];
      end
    end
  end

  // Source index steps by direction flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_index <= `OOPE_REG_RST;
    end else if (ce) begin
      if (wr_idle && paddr == `OOPE_SRC_OFS) begin
        src_index <= pwdata[15:0];
      end else if (string_output_instr_step) begin
        src_index <= flags[`OOPE_FLG_DF] ? src_index - step : src_index + step;
      end
    end
  end

  // Repeat count per element
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `OOPE_REG_RST;
    end else if (ce) begin
      if (wr_idle && paddr == `OOPE_COUNT_OFS) begin
        count <= pwdata[15:0];
      end else if (string_output_instr_step && cmd_q[`OOPE_CMD_REP]) begin
        count <= count - 16'h0001;
      end
    end
  end

  // Stack pointer past popped word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pointer_reg <= `OOPE_REG_RST;
    end else if (ce) begin
      if (wr_idle && paddr == `OOPE_SP_OFS) begin
        stack_pointer_reg <= pwdata[15:0];
      end else if (pop_got) begin
        stack_pointer_reg <= stack_pointer_reg + `OOPE_POP_STEP;
      end
    end
  end

  // Software-only operand registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_index_reg <= `OOPE_REG_RST;
      opb            <= `OOPE_REG_RST;
      mem_ofs        <= `OOPE_REG_RST;
      imm8           <= 8'h00;
    end else if (ce && wr_idle) begin
      if (paddr == `OOPE_PORT_OFS) begin
        port_index_reg <= pwdata[15:0];
      end else if (paddr == `OOPE_OPB_OFS) begin
        opb <= pwdata[15:0];
      end else if (paddr == `OOPE_MOFS_OFS) begin
        mem_ofs <= pwdata[15:0];
      end else if (paddr == `OOPE_IMM8_OFS) begin
        imm8 <= pwdata[7:0];
      end
    end
  end

  // Segment registers
  for (genvar g = 0; g < 4; g++) begin : g_seg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        seg_reg[g] <= `OOPE_REG_RST;
      end else if (ce) begin
        if (wr_idle && paddr == `OOPE_SEG0_OFS + 8'(4 * g)) begin
          seg_reg[g] <= pwdata[15:0];
        end else if (pop_got && pdst == PDST_SEG && cmd_q[`OOPE_CMD_SEG] == 2'(g)) begin
          seg_reg[g] <= mem_rdata;
        end
      end
    end
  end

  // ****************************************
  // Memory bus
  // ****************************************
  // Word: low byte at address, high at next
  always_comb begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_word  = is_word;
    mem_wdata = res;
    mem_addr  = {dseg, 4'h0} + {4'h0, mem_ofs};
    case (state)
      ST_MRD: begin
        mem_req = 1'b1;
      end
      ST_MWR: begin
        mem_req = 1'b1;
        mem_we  = 1'b1;
      end
      ST_SRD: begin
        mem_req  = 1'b1;
        mem_addr = {dseg, 4'h0} + {4'h0, src_index};
      end
      ST_PRD: begin
        mem_req  = 1'b1;
        mem_word = 1'b1;
        mem_addr = {seg_reg[`OOPE_SEG_SS], 4'h0} + {4'h0, stack_pointer_reg};
      end
      ST_PWR: begin
        mem_req   = 1'b1;
        mem_we    = 1'b1;
        mem_word  = 1'b1;
        mem_wdata = mem_data;
      end
      default: ;
    endcase
  end

  // ****************************************
  // Port output path
  // ****************************************
  // Entry is {word, port, data}; a full FIFO stalls the sequencer
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data  = {is_word, port_index_reg, mem_data};
    if (state == ST_IOQ) begin
      fifo_in_valid = 1'b1;
      fifo_in_data  = {is_word,
                       cmd_q[`OOPE_CMD_IDX] ? port_index_reg : {8'h00, imm8},
                       is_word ? accum_word : {8'h00, accum_word[7:0]}};
    end else if (state == ST_SPUSH) begin
      fifo_in_valid = 1'b1;
      fifo_in_data  = {is_word, port_index_reg,
                       is_word ? mem_data : {8'h00, mem_data[7:0]}};
    end
  end

  oope_fifo #(
    .WIDTH (33),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (io_valid),
    .out_ready (io_ready),
    .out_data  (fifo_out_data),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  assign io_word = fifo_out_data[32];
  assign io_addr = fifo_out_data[31:16];
  assign io_data = fifo_out_data[15:0];
endmodule

// ===== oope_mem_model.sv
`timescale 1ns/100ps
// ****************************************
// Memory partner, fixed byte pattern
// ****************************************
module oope_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Request side
  input  wire logic        mem_req,
  input  wire logic [19:0] mem_addr,
  input  wire logic [1:0]  dly,
  // Answer side
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [1:0] cnt;
  logic [7:0] lo;
  // Byte value is its low address byte
  assign lo = mem_addr[7:0];
  // Little endian; inverted outside ack to expose stale use
  assign mem_rdata = mem_ack ? {lo + 8'h01, lo} : ~{lo + 8'h01, lo};
  // One-cycle ack after dly extra cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt     <= 2'h0;
      mem_ack <= 1'b0;
    end else begin
      mem_ack <= mem_req && !mem_ack && cnt == dly;
      cnt     <= (mem_req && !mem_ack && cnt != dly) ? cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// ===== oope_exec_monitor.sv
`timescale 1ns/100ps
// ****************************************
// Port checker
// ****************************************
module oope_exec_monitor (
  // Clock, reset, enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // Memory and port buses
  input wire logic        mem_req,
  input wire logic        mem_ack,
  input wire logic [19:0] mem_addr,
  input wire logic        io_valid,
  input wire logic        io_ready,
  input wire logic        io_word,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] io_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup then enabled access phase
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_access;
    psel && penable && ce;
  endsequence
  a_zero_wait: assert property (s_setup ##1 s_access |-> pready) else $error("pready late");
  a_err_unmap: assert property (pready && paddr > 8'h3c |-> pslverr) else $error("no slverr");
  a_err_clean: assert property (pready && paddr <= 8'h3c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("slverr on mapped");
  a_err_only: assert property (pslverr |-> pready) else $error("slverr alone");
  a_ce_freeze: assert property (!ce |-> !pready) else $error("pready while frozen");
  // Memory request held until taken
  a_mem_hold: assert property (mem_req && !(mem_ack && ce) |=>
    mem_req && $stable(mem_addr)) else $error("mem request dropped");
  a_io_hold: assert property (io_valid && !(io_ready && ce) |=>
    io_valid && $stable(io_data) && $stable(io_addr)) else $error("port write dropped");
  a_io_byte: assert property (io_valid && !io_word |-> io_data[15:8] == 8'h00)
    else $error("byte upper not zero");
endmodule

bind oope_exec oope_exec_monitor u_mon (.pclk(pclk), .presetn(presetn), .ce(ce),
  .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_ack(mem_ack), .mem_addr(mem_addr), .io_valid(io_valid),
  .io_ready(io_ready), .io_word(io_word), .io_addr(io_addr), .io_data(io_data));

// ===== oope_exec_tb.sv
`timescale 1ns/100ps
module oope_exec_tb;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, perr;
  logic        mem_req, mem_we, mem_word, mem_ack, io_valid, io_word, io_ready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata, io_addr, io_data;
  logic [1:0]  dly;
  logic [32:0] io_q[$];
  int          err_total, n_checks;
  oope_exec dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .io_valid(io_valid), .io_word(io_word), .io_addr(io_addr), .io_data(io_data),
    .io_ready(io_ready));
  oope_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .dly(dly), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Log accepted port writes
  always @(posedge pclk) begin
    if (io_valid && io_ready && ce) begin
      io_q.push_back({io_word, io_addr, io_data});
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  // APB transfer, bounded wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (i >= 50) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, {1'b0, rd}, {1'b0, e});
  endtask
  // Wait until idle and drained
  task automatic settle;
    int i;
    for (i = 0; i < 100; i++) begin
      apb(1'b0, 8'h04, 32'h0);
      if (rd[0] === 1'b0 && rd[2] === 1'b1) return;
    end
    err_total++;
    tally_and_finish;
  endtask
  task automatic run(input logic [31:0] c);
    wr(8'h00, c);
    settle;
  endtask
  task automatic or_case(input logic [7:0] da, input logic [15:0] dv, b, input logic [31:0] c,
    input logic [15:0] e, f);
    wr(8'h18, 32'h0c01);
    wr(da, {16'h0, dv});
    wr(8'h20, {16'h0, b});
    run(c);
    rdc(da, {16'h0, e}, "or result");
    rdc(8'h18, {16'h0, f}, "or flags");
  endtask
  // Stalled string output, drain, compare
  task automatic string_output_instr_run(input logic [31:0] c, input logic [15:0] f, input int n,
    input logic [19:0] base, input logic [15:0] si, st);
    logic [15:0] a;
    logic [7:0]  b;
    int k;
    wr(8'h18, {16'h0, f});
    wr(8'h10, {16'h0, si});
    wr(8'h28, 32'(n));
    io_ready <= 1'b0;
    wr(8'h00, c);
    repeat (40) @(posedge pclk);
    if (n > 8) rdc(8'h04, 32'h9, "fifo full");
    io_ready <= 1'b1;
    settle;
    chk("string_output_instr count", 33'(io_q.size()), 33'(n));
    for (k = 0; k < n; k++) begin
      a = si + 16'(k) * st;
      b = 8'(base + 20'(a));
      chk("string_output_instr data", io_q.pop_front(), c[5] ? {1'b1, 16'hffff, b + 8'h1, b}
        : {1'b0, 16'hffff, 8'h0, b});
    end
    rdc(8'h10, {16'h0, si + 16'(n) * st}, "src index");
    rdc(8'h18, {16'h0, f}, "string_output_instr flags");
  endtask
  initial begin
    presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; io_ready = 1'b1; dly = 2'h0;
    err_total = 0; n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h08, 32'h0, "accum reset");
    wr(8'h3c, 32'h1000);
    wr(8'h24, 32'h0010);
    dly <= 2'h2;
    or_case(8'h1c, 16'h8001, 16'h0600, 32'h20, 16'h8601, 16'h0480);
    or_case(8'h08, 16'hab00, 16'h0000, 32'h0c, 16'hab00, 16'h0444);
    or_case(8'h1c, 16'h0001, 16'h0000, 32'h24, 16'h1111, 16'h0404);
    wr(8'h08, 32'h1234);
    wr(8'h2c, 32'hff);
    wr(8'h0c, 32'hffff);
    run(32'h01);
    run(32'ha1);
    chk("out imm", io_q.pop_front(), {1'b0, 16'h00ff, 16'h0034});
    chk("out idx", io_q.pop_front(), {1'b1, 16'hffff, 16'h1234});
    rdc(8'h18, 32'h0404, "out flags");
    wr(8'h30, 32'h2000);
    dly <= 2'h1;
    string_output_instr_run(32'h42, 16'h0000, 10, 20'h10000, 16'h0020, 16'h0001);
    string_output_instr_run(32'h162, 16'h0400, 2, 20'h20000, 16'h0050, 16'hfffe);
    wr(8'h38, 32'h0300);
    wr(8'h14, 32'h0040);
    run(32'h03);
    rdc(8'h1c, 32'h4140, "pop value");
    rdc(8'h14, 32'h0042, "stack ptr");
    rdc(8'h18, 32'h0400, "pop flags");
    run(32'ha03);
    rdc(8'h04, 32'h6, "pop code seg");
    rdc(8'h14, 32'h0042, "sp kept");
    wr(8'h04, 32'h2);
    rdc(8'h04, 32'h4, "illegal clear");
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {perr, rd}, 33'h100000000);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    tally_and_finish;
  end
endmodule
